/* File: rtl/front_panel_map.vh */
// What this block does
// - Lock lamp dark until reference valid
// - Lock lamp blinks while locking, steady locked
// - Fault lamp blinks amber awaiting valid reference
// - Valid reference: amber while locking, dark locked
// - Fault lamp steady amber during holdover
// - Fault lamp alternates green/red, reference absent
// - Fault lamp steady red on catastrophic fault
// - Menu key lists displays, four per page
// - Page-down key advances to next page
// - Forward key moves cursor, ENTER shows entry
// - Digit one to nine jumps to display
// - Ten idle seconds after menu: default display
// - ENTER while setting default stores it
// - Display one: day of year then time
// - Display two: date in chosen order, time
// - Display three: weekday, month, day, year, time
// - Am/pm only for local twelve-hour time
`ifndef FRONT_PANEL_MAP_VH
`define FRONT_PANEL_MAP_VH

// Timing
`define CLK_FREQ_HZ 100000000
`define IDLE_TIMEOUT_S 10
`define IDLE_CYCLES_DEF 30'h3b9aca00
`define IDLE_CNT_W 30
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYCLES_DEF 26'h17d7840
`define BLINK_CNT_W 26

// Register map
`define AXI_AW 8
`define OFS_CTRL 8'h00
`define OFS_DEFAULT 8'h04
`define OFS_STATUS 8'h08
`define OFS_INT_STAT 8'h0c
`define OFS_INT_CLR 8'h10
`define OFS_INT_EN 8'h14
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Control fields
`define CTRL_DATE_ORDER 1:0
`define CTRL_LOCAL 2
`define CTRL_TWELVE 3
`define CTRL_SET_DEF 4
`define CTRL_W 5
`define CTRL_RST 5'h00
`define DATE_MDY 2'h0
`define DATE_DMY 2'h1
`define DATE_YMD 2'h2

// Displays and menu
`define NUM_DISPLAYS 4'h9
`define DEFAULT_RST 4'h1
`define DISP_TIME 4'h1
`define DISP_DATE 4'h2
`define DISP_WEEKDAY 4'h3

// Layout codes
`define LAY_DOY_TIME 3'h0
`define LAY_MDY_TIME 3'h1
`define LAY_DMY_TIME 3'h2
`define LAY_YMD_TIME 3'h3
`define LAY_WEEKDAY_TIME 3'h4
`define LAY_OTHER 3'h5

// Interrupt bits
`define INT_W 4
`define INT_TIMEOUT 0
`define INT_CAT 1
`define INT_ABSENT 2
`define INT_DEFSET 3

// Key synchroniser lanes
`define KEY_W 9
`define KEY_CODE 3:0
`define KEY_MENU 4
`define KEY_PAGE 5
`define KEY_FWD 6
`define KEY_ENTER 7
`define KEY_DIGIT 8

`endif

/* File: rtl/key_sync.v */
`timescale 1ns/1ps
`include "front_panel_map.vh"

module key_sync (
	input wire clk_sys_i,
	input wire rst_i,
	input wire [`KEY_W-1:0] raw_i,
	output wire [`KEY_W-1:0] level_o,
	output wire [`KEY_W-1:0] rise_o
);

reg [`KEY_W-1:0] meta_r;
reg [`KEY_W-1:0] stable_r;
reg [`KEY_W-1:0] prev_r;

genvar g;
generate
	for (g = 0; g < `KEY_W; g = g + 1) begin : g_lane
		// Two flops, then a delayed copy for edges
		always @(posedge clk_sys_i or posedge rst_i) begin
			if (rst_i) begin
				meta_r[g] <= 1'b0;
				stable_r[g] <= 1'b0;
				prev_r[g] <= 1'b0;
			end else begin
				meta_r[g] <= raw_i[g];
				stable_r[g] <= meta_r[g];
				prev_r[g] <= stable_r[g];
			end
		end
		assign rise_o[g] = stable_r[g] & ~prev_r[g];
	end
endgenerate

assign level_o = stable_r;

endmodule // key_sync

/* File: rtl/front_panel_status_indicator.v */
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "front_panel_map.vh"

module front_panel_status_indicator #(
	parameter [`IDLE_CNT_W-1:0] IDLE_CYCLES = `IDLE_CYCLES_DEF,
	parameter [`BLINK_CNT_W-1:0] BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES_DEF
) (
	input wire clk_sys_i,
	input wire rst_i,
	// Instrument conditions, same clock
	input wire ref_valid_i,
	input wire osc_locked_i,
	input wire holdover_i,
	input wire ref_absent_i,
	input wire cat_fault_i,
	// Keypad pins
	input wire key_menu_i,
	input wire key_page_i,
	input wire key_fwd_i,
	input wire key_enter_i,
	input wire key_digit_i,
	input wire [3:0] key_code_i,
	// Lamps
	output reg lock_led_o,
	output reg fault_red_o,
	output reg fault_green_o,
	// Display control
	output reg menu_active_o,
	output reg [1:0] page_o,
	output reg [1:0] cursor_o,
	output reg [3:0] disp_sel_o,
	output reg [2:0] layout_o,
	output reg ampm_o,
	output reg irq_o,
	// AXI4-Lite slave
	input wire [`AXI_AW-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [`AXI_AW-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i
);

localparam S_DISPLAY = 1'b0;
localparam S_MENU = 1'b1;

////////////////////////////////////////////////////////////////////////////
// Keypad synchronisation

wire [`KEY_W-1:0] key_level;
wire [`KEY_W-1:0] key_rise;
wire [3:0] digit_code;
wire any_key;

key_sync u_key_sync (
	.clk_sys_i(clk_sys_i),
	.rst_i(rst_i),
	.raw_i({key_digit_i, key_enter_i, key_fwd_i, key_page_i, key_menu_i,
		key_code_i}),
	.level_o(key_level),
	.rise_o(key_rise)
);

// Code is held stable while its strobe is up
assign digit_code = key_level[`KEY_CODE];
assign any_key = |key_rise[`KEY_W-1:`KEY_MENU];

////////////////////////////////////////////////////////////////////////////
// Register state

reg [`CTRL_W-1:0] ctrl_r;
reg [3:0] default_r;
reg [3:0] default_nxt;
reg [`INT_W-1:0] int_stat_r;
reg [`INT_W-1:0] int_en_r;
reg [`INT_W-1:0] int_ev;
reg [`INT_W-1:0] int_clr;
reg cat_prev_r;
reg absent_prev_r;

wire wr_fire;
wire rd_fire;
wire wr_lane0;
reg [31:0] rdata_nxt;
reg rd_hit;
reg wr_hit;

////////////////////////////////////////////////////////////////////////////
// Blink phase, shared by every flashing lamp

reg [`BLINK_CNT_W-1:0] blink_cnt_r;
reg blink_r;

// Toggles phase every half period
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		blink_cnt_r <= {`BLINK_CNT_W{1'b0}};
		blink_r <= 1'b0;
	end else if (blink_cnt_r == BLINK_HALF_CYCLES - 1'b1) begin
		blink_cnt_r <= {`BLINK_CNT_W{1'b0}};
		blink_r <= ~blink_r;
	end else begin
		blink_cnt_r <= blink_cnt_r + 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////
// Lamp drive

reg lock_nxt;
reg red_nxt;
reg green_nxt;

// Priority: fault, absent, holdover, acquisition
always @* begin
	if (!ref_valid_i)
		lock_nxt = 1'b0;
	else if (!osc_locked_i)
		lock_nxt = blink_r;
	else
		lock_nxt = 1'b1;
	if (cat_fault_i) begin
		red_nxt = 1'b1;
		green_nxt = 1'b0;
	end else if (ref_absent_i) begin
		red_nxt = blink_r;
		green_nxt = ~blink_r;
	end else if (holdover_i) begin
		red_nxt = 1'b1;
		green_nxt = 1'b1;
	end else if (!ref_valid_i) begin
		red_nxt = blink_r;
		green_nxt = blink_r;
	end else if (!osc_locked_i) begin
		red_nxt = 1'b1;
		green_nxt = 1'b1;
	end else begin
		red_nxt = 1'b0;
		green_nxt = 1'b0;
	end
end

// Lamp outputs from flops
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		lock_led_o <= 1'b0;
		fault_red_o <= 1'b0;
		fault_green_o <= 1'b0;
	end else begin
		lock_led_o <= lock_nxt;
		fault_red_o <= red_nxt;
		fault_green_o <= green_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////
// Menu and display selection

reg state_r;
reg [1:0] page_r;
reg [1:0] cursor_r;
reg [3:0] disp_r;
reg [`IDLE_CNT_W-1:0] idle_cnt_r;
wire [1:0] page_inc;
wire [1:0] cursor_inc;
wire [3:0] entry;
wire idle_done;
wire digit_ok;

assign page_inc = page_r + 2'h1;
assign cursor_inc = cursor_r + 2'h1;
assign entry = {page_r, cursor_r} + 4'h1;
assign idle_done = (state_r == S_MENU) &&
	(idle_cnt_r == IDLE_CYCLES - 1'b1);
assign digit_ok = key_rise[`KEY_DIGIT] && (digit_code != 4'h0) &&
	(digit_code <= `NUM_DISPLAYS);

// Menu walk, shortcuts and idle return
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		state_r <= S_DISPLAY;
		page_r <= 2'h0;
		cursor_r <= 2'h0;
		disp_r <= `DEFAULT_RST;
		idle_cnt_r <= {`IDLE_CNT_W{1'b0}};
	end else begin
		if (any_key || state_r == S_DISPLAY)
			idle_cnt_r <= {`IDLE_CNT_W{1'b0}};
		else
			idle_cnt_r <= idle_cnt_r + 1'b1;
		if (key_rise[`KEY_MENU]) begin
			state_r <= S_MENU;
			page_r <= 2'h0;
			cursor_r <= 2'h0;
		end else if (digit_ok) begin
			state_r <= S_DISPLAY;
			disp_r <= digit_code;
		end else begin
			case (state_r)
			S_MENU: begin
				if (key_rise[`KEY_PAGE]) begin
					cursor_r <= 2'h0;
					if ({page_inc, 2'h0} >= `NUM_DISPLAYS)
						page_r <= 2'h0;
					else
						page_r <= page_inc;
				end else if (key_rise[`KEY_FWD]) begin
					if ({page_r, cursor_inc} >= `NUM_DISPLAYS ||
						cursor_inc == 2'h0)
						cursor_r <= 2'h0;
					else
						cursor_r <= cursor_inc;
				end else if (key_rise[`KEY_ENTER]) begin
					state_r <= S_DISPLAY;
					disp_r <= entry;
				end else if (idle_done) begin
					state_r <= S_DISPLAY;
					disp_r <= default_r;
				end
			end
			default: begin
				state_r <= S_DISPLAY;
			end
			endcase
		end
	end
end

// Display outputs and layout
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		menu_active_o <= 1'b0;
		page_o <= 2'h0;
		cursor_o <= 2'h0;
		disp_sel_o <= `DEFAULT_RST;
		layout_o <= `LAY_DOY_TIME;
		ampm_o <= 1'b0;
	end else begin
		menu_active_o <= state_r;
		page_o <= page_r;
		cursor_o <= cursor_r;
		disp_sel_o <= disp_r;
		ampm_o <= ctrl_r[`CTRL_LOCAL] & ctrl_r[`CTRL_TWELVE];
		if (disp_r == `DISP_TIME)
			layout_o <= `LAY_DOY_TIME;
		else if (disp_r == `DISP_WEEKDAY)
			layout_o <= `LAY_WEEKDAY_TIME;
		else if (disp_r != `DISP_DATE)
			layout_o <= `LAY_OTHER;
		else if (ctrl_r[`CTRL_DATE_ORDER] == `DATE_DMY)
			layout_o <= `LAY_DMY_TIME;
		else if (ctrl_r[`CTRL_DATE_ORDER] == `DATE_YMD)
			layout_o <= `LAY_YMD_TIME;
		else
			layout_o <= `LAY_MDY_TIME;
	end
end

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite handshakes

assign wr_fire = s_axi_awvalid_i & s_axi_awready_o &
	s_axi_wvalid_i & s_axi_wready_o;
assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;
assign wr_lane0 = wr_fire & s_axi_wstrb_i[0];

// Address and data taken together, one write at a time
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		s_axi_awready_o <= 1'b0;
		s_axi_wready_o <= 1'b0;
		s_axi_bvalid_o <= 1'b0;
		s_axi_bresp_o <= `RESP_OKAY;
		s_axi_arready_o <= 1'b0;
		s_axi_rvalid_o <= 1'b0;
		s_axi_rresp_o <= `RESP_OKAY;
		s_axi_rdata_o <= 32'h0;
	end else begin
		s_axi_awready_o <= s_axi_awvalid_i & s_axi_wvalid_i &
			~s_axi_awready_o & ~s_axi_bvalid_o;
		s_axi_wready_o <= s_axi_awvalid_i & s_axi_wvalid_i &
			~s_axi_awready_o & ~s_axi_bvalid_o;
		if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
		s_axi_arready_o <= s_axi_arvalid_i & ~s_axi_arready_o &
			~s_axi_rvalid_o;
		if (rd_fire) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rdata_nxt;
			s_axi_rresp_o <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end
end

// Write decode
always @* begin
	wr_hit = 1'b1;
	int_clr = {`INT_W{1'b0}};
	default_nxt = default_r;
	case (s_axi_awaddr_i)
	`OFS_CTRL, `OFS_INT_EN: wr_hit = 1'b1;
	`OFS_DEFAULT: begin
		if (wr_lane0 && s_axi_wdata_i[3:0] != 4'h0 &&
			s_axi_wdata_i[3:0] <= `NUM_DISPLAYS)
			default_nxt = s_axi_wdata_i[3:0];
	end
	`OFS_INT_CLR: begin
		if (wr_lane0)
			int_clr = s_axi_wdata_i[`INT_W-1:0];
	end
	default: wr_hit = 1'b0;
	endcase
	// Operator choice beats a same-cycle bus write
	if (state_r == S_MENU && key_rise[`KEY_ENTER] &&
		!key_rise[`KEY_MENU] && !digit_ok && ctrl_r[`CTRL_SET_DEF])
		default_nxt = entry;
end

// Read decode
always @* begin
	rd_hit = 1'b1;
	rdata_nxt = 32'h0;
	case (s_axi_araddr_i)
	`OFS_CTRL: rdata_nxt[`CTRL_W-1:0] = ctrl_r;
	`OFS_DEFAULT: rdata_nxt[3:0] = default_r;
	`OFS_STATUS: rdata_nxt[11:0] = {fault_green_o, fault_red_o,
		lock_led_o, cursor_r, page_r, state_r, disp_r};
	`OFS_INT_STAT: rdata_nxt[`INT_W-1:0] = int_stat_r;
	`OFS_INT_EN: rdata_nxt[`INT_W-1:0] = int_en_r;
	`OFS_INT_CLR: rdata_nxt = 32'h0;
	default: rd_hit = 1'b0;
	endcase
end

// Control, default and enable registers
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		ctrl_r <= `CTRL_RST;
		default_r <= `DEFAULT_RST;
		int_en_r <= {`INT_W{1'b0}};
	end else begin
		default_r <= default_nxt;
		if (wr_lane0 && s_axi_awaddr_i == `OFS_CTRL)
			ctrl_r <= s_axi_wdata_i[`CTRL_W-1:0];
		if (wr_lane0 && s_axi_awaddr_i == `OFS_INT_EN)
			int_en_r <= s_axi_wdata_i[`INT_W-1:0];
	end
end

////////////////////////////////////////////////////////////////////////////
// Interrupts

// Event sources
always @* begin
	int_ev = {`INT_W{1'b0}};
	int_ev[`INT_TIMEOUT] = idle_done & ~digit_ok &
		~|key_rise[`KEY_ENTER:`KEY_MENU];
	int_ev[`INT_CAT] = cat_fault_i & ~cat_prev_r;
	int_ev[`INT_ABSENT] = ref_absent_i & ~absent_prev_r;
	int_ev[`INT_DEFSET] = (default_nxt != default_r);
end

genvar b;
generate
	for (b = 0; b < `INT_W; b = b + 1) begin : g_int
		// Sticky bit, set beats clear
		always @(posedge clk_sys_i or posedge rst_i) begin
			if (rst_i)
				int_stat_r[b] <= 1'b0;
			else
				int_stat_r[b] <= int_ev[b] | (int_stat_r[b] & ~int_clr[b]);
		end
	end
endgenerate

// Edge history and interrupt output
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		cat_prev_r <= 1'b0;
		absent_prev_r <= 1'b0;
		irq_o <= 1'b0;
	end else begin
		cat_prev_r <= cat_fault_i;
		absent_prev_r <= ref_absent_i;
		irq_o <= |((int_ev | (int_stat_r & ~int_clr)) & int_en_r);
	end
end

endmodule // front_panel_status_indicator

/* File: test/fpsi_asserts.sv */
`timescale 1ns/1ps
module fpsi_asserts (
	input wire clk_sys_i,
	input wire rst_i,
	input wire ref_valid_i,
	input wire osc_locked_i,
	input wire holdover_i,
	input wire ref_absent_i,
	input wire cat_fault_i,
	input wire key_menu_i,
	input wire key_digit_i,
	input wire [3:0] key_code_i,
	input wire lock_led_o,
	input wire fault_red_o,
	input wire fault_green_o,
	input wire menu_active_o,
	input wire [1:0] page_o,
	input wire [1:0] cursor_o,
	input wire [3:0] disp_sel_o,
	input wire [2:0] layout_o
);
	wire calm;
	wire red;
	wire grn;
	// No higher-priority fault condition
	assign calm = !cat_fault_i && !ref_absent_i && !holdover_i;
	assign red = fault_red_o;
	assign grn = fault_green_o;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Key press steps
	sequence s_menu; $rose(key_menu_i); endsequence
	sequence s_dig; $rose(key_digit_i) && key_code_i inside {[1:9]}; endsequence
	//////////////////////////////////////////////////////////////////////
	property p_dark; !ref_valid_i |=> !lock_led_o; endproperty
	a_dark: assert property (p_dark) else $error("lock lamp lit");
	property p_lock; ref_valid_i && osc_locked_i |=> lock_led_o; endproperty
	a_lock: assert property (p_lock) else $error("lock lamp off");
	property p_wait; !ref_valid_i && calm |=> red == grn; endproperty
	a_wait: assert property (p_wait) else $error("not amber");
	property p_pull; ref_valid_i && !osc_locked_i && calm |=> red && grn;
	endproperty
	a_pull: assert property (p_pull) else $error("not amber");
	property p_ok; ref_valid_i && osc_locked_i && calm |=> !red && !grn;
	endproperty
	a_ok: assert property (p_ok) else $error("fault lamp lit");
	property p_hold; holdover_i && !cat_fault_i && !ref_absent_i |=> red && grn;
	endproperty
	a_hold: assert property (p_hold) else $error("no holdover amber");
	property p_alt; ref_absent_i && !cat_fault_i |=> red != grn; endproperty
	a_alt: assert property (p_alt) else $error("not alternating");
	property p_cat; cat_fault_i |=> red && !grn; endproperty
	a_cat: assert property (p_cat) else $error("not red");
	property p_menu; s_menu |-> ##[1:8] (menu_active_o && page_o == 2'h0 &&
		cursor_o == 2'h0); endproperty
	a_menu: assert property (p_menu) else $error("no listing");
	property p_dig; s_dig |-> ##[1:8] (disp_sel_o == key_code_i); endproperty
	a_dig: assert property (p_dig) else $error("no jump");
	property p_one; $stable(disp_sel_o) && disp_sel_o == 4'h1 |->
		layout_o == 3'h0; endproperty
	a_one: assert property (p_one) else $error("bad layout");
	property p_three; $stable(disp_sel_o) && disp_sel_o == 4'h3 |->
		layout_o == 3'h4; endproperty
	a_three: assert property (p_three) else $error("bad layout");
endmodule // fpsi_asserts

bind front_panel_status_indicator fpsi_asserts i_fpsi_asserts (.clk_sys_i,
	.rst_i, .ref_valid_i, .osc_locked_i, .holdover_i, .ref_absent_i,
	.cat_fault_i, .key_menu_i, .key_digit_i, .key_code_i, .lock_led_o,
	.fault_red_o, .fault_green_o, .menu_active_o, .page_o, .cursor_o,
	.disp_sel_o, .layout_o);

/* File: test/keypad_model.sv */
`timescale 1ns/1ps
module keypad_model (
	input wire clk_sys_i,
	output wire [4:0] keys_o,
	output reg [3:0] key_code_o
);
	reg [4:0] keys_r = 5'h00;
	assign keys_o = keys_r;
	initial key_code_o = 4'h0;
	// One operator press: code settles first, key held, then released
	task press(input integer k, input [3:0] c);
		begin
			@(posedge clk_sys_i);
			key_code_o <= c;
			repeat (3) @(posedge clk_sys_i);
			keys_r <= 5'h01 << k;
			repeat (7) @(posedge clk_sys_i);
			keys_r <= 5'h00;
			key_code_o <= ~c; // Undriven code lines wander
			repeat (4) @(posedge clk_sys_i);
		end
	endtask
endmodule // keypad_model

/* File: test/front_panel_status_indicator_tb.sv */
`timescale 1ns/1ps
module front_panel_status_indicator_tb;
	reg clk_sys_i, rst_i, awv, wv, bry, arv, rry;
	reg [4:0] cond;
	reg [7:0] aw, ar;
	reg [31:0] wd;
	wire [4:0] keys;
	wire [3:0] code, disp;
	wire lock, red, grn, menu, ampm, irq, awr, wrr, bv, arr, rv;
	wire [1:0] page, cur, bresp, rresp;
	wire [2:0] lay;
	wire [31:0] rdata;
	integer errors, comparisons, seed, d, m, pg, cu, def, sd, dord, i, n;
	integer cyc = 0;
	front_panel_status_indicator #(.IDLE_CYCLES(30'd200),
		.BLINK_HALF_CYCLES(26'd8)) i_front_panel_status_indicator (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ref_valid_i(cond[0]),
		.osc_locked_i(cond[1]), .holdover_i(cond[2]), .ref_absent_i(cond[3]),
		.cat_fault_i(cond[4]), .key_menu_i(keys[0]), .key_page_i(keys[1]),
		.key_fwd_i(keys[2]), .key_enter_i(keys[3]), .key_digit_i(keys[4]),
		.key_code_i(code), .lock_led_o(lock), .fault_red_o(red),
		.fault_green_o(grn), .menu_active_o(menu), .page_o(page),
		.cursor_o(cur), .disp_sel_o(disp), .layout_o(lay), .ampm_o(ampm),
		.irq_o(irq), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ar),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry));
	keypad_model i_keypad_model (.clk_sys_i(clk_sys_i), .keys_o(keys),
		.key_code_o(code));
	//////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			end_of_test;
		end
	end
	// Compare and count
	task check(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("comparisons %0d errors %0d", comparisons, errors);
			if (errors == 0 && comparisons > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Bus master write and read
	task wr(input [7:0] a, input [31:0] v, input [1:0] er);
		begin
			@(posedge clk_sys_i);
			aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
			n = 0;
			while (n == 0) begin
				@(posedge clk_sys_i);
				if (awr === 1'b1) awv <= 1'b0;
				if (wrr === 1'b1) wv <= 1'b0;
				if (bv === 1'b1) n = 1;
			end
			bry <= 1'b0;
			check(bresp, er);
		end
	endtask
	task rd(input [7:0] a, input [31:0] ev, input [1:0] er);
		begin
			@(posedge clk_sys_i);
			ar <= a; arv <= 1'b1; rry <= 1'b1;
			n = 0;
			while (n == 0) begin
				@(posedge clk_sys_i);
				if (arr === 1'b1) arv <= 1'b0;
				if (rv === 1'b1) n = 1;
			end
			rry <= 1'b0;
			check(rdata, ev);
			check(rresp, er);
		end
	endtask
	function integer explay(input integer dd, input integer o);
		explay = dd == 1 ? 0 : dd == 3 ? 4 : dd != 2 ? 5 :
			o == 1 ? 2 : o == 2 ? 3 : 1;
	endfunction
	// Key press with menu model update
	task key(input integer k, input [3:0] c);
		begin
			i_keypad_model.press(k, c);
			case (k)
				0: begin m = 1; pg = 0; cu = 0; end
				1: if (m) begin pg = (pg + 1) % 3; cu = 0; end
				2: if (m) cu = (cu == 3 || pg * 4 + cu >= 8) ? 0 : cu + 1;
				3: if (m) begin d = pg * 4 + cu + 1; m = 0; if (sd) def = d; end
				4: if (c >= 1 && c <= 9) begin d = c; m = 0; end
			endcase
			check(disp, d);
			check(menu, m);
			check(lay, explay(d, dord));
			if (m) check({page, cur}, pg * 4 + cu);
		end
	endtask
	// Lamp pattern over 20 cycles, 1.25 blink periods: 0 off 1 on 2 blink 3 red 4 alt
	task lamp(input [4:0] c, input integer el, input integer ef);
		integer on, off, am, dk, ro, go;
		begin
			cond <= c;
			repeat (3) @(posedge clk_sys_i);
			on = 0; off = 0; am = 0; dk = 0; ro = 0; go = 0;
			repeat (20) begin
				@(posedge clk_sys_i);
				if (lock === 1'b1) on = 1;
				if (lock === 1'b0) off = 1;
				if ({red, grn} === 2'b11) am = 1;
				if ({red, grn} === 2'b00) dk = 1;
				if ({red, grn} === 2'b10) ro = 1;
				if ({red, grn} === 2'b01) go = 1;
			end
			check(on && off ? 2 : on ? 1 : off ? 0 : 9, el);
			check(ro && go ? 4 : am && dk ? 2 : am ? 1 : ro ? 3 : dk ? 0 : 9, ef);
		end
	endtask
	task irqc(input e);
		begin
			@(posedge clk_sys_i);
			check(irq, e);
		end
	endtask
	//////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_i = 1'b1; cond = 5'h00; aw = 8'h00; ar = 8'h00; wd = 32'h0;
		{awv, wv, bry, arv, rry} = 5'h00;
		errors = 0; comparisons = 0; seed = 32'hd51c;
		d = 1; m = 0; pg = 0; cu = 0; def = 1; sd = 0; dord = 0;
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(8'h00, 0, 0);
		rd(8'h04, 1, 0);
		rd(8'h14, 0, 0);
		rd(8'h18, 0, 2);
		wr(8'h18, 1, 2);
		lamp(5'h00, 0, 2);
		lamp(5'h01, 2, 1);
		lamp(5'h03, 1, 0);
		lamp(5'h07, 1, 1);
		lamp(5'h0f, 1, 4);
		lamp(5'h1f, 1, 3);
		key(4, 1);
		key(4, 3);
		key(4, 2);
		for (i = 0; i < 16; i = i + 1) begin
			wr(8'h00, i, 0);
			dord = i % 4;
			repeat (2) @(posedge clk_sys_i);
			check(lay, explay(2, dord));
			check(ampm, i / 4 == 3);
		end
		wr(8'h00, 0, 0);
		dord = 0;
		key(1, 0);
		key(0, 0);
		key(1, 0);
		key(2, 0);
		key(2, 0);
		key(3, 0);
		key(0, 0);
		for (i = 0; i < 5; i = i + 1)
			key(1, 0);
		key(2, 0);
		key(3, 0);
		wr(8'h00, 16, 0);
		sd = 1;
		key(0, 0);
		key(2, 0);
		key(3, 0);
		rd(8'h04, 2, 0);
		wr(8'h00, 0, 0);
		sd = 0;
		wr(8'h04, 5, 0);
		wr(8'h04, 0, 0);
		rd(8'h04, 5, 0);
		def = 5;
		wr(8'h10, 15, 0);
		wr(8'h14, 1, 0);
		irqc(1'b0);
		key(0, 0);
		repeat (200) @(posedge clk_sys_i);
		check({menu, disp, lay}, {1'b0, 4'h5, 3'h5});
		irqc(1'b1);
		rd(8'h0c, 1, 0);
		wr(8'h14, 0, 0);
		irqc(1'b0);
		wr(8'h14, 1, 0);
		irqc(1'b1);
		wr(8'h10, 1, 0);
		irqc(1'b0);
		rd(8'h0c, 0, 0);
		d = 5; m = 0;
		for (i = 0; i < 6; i = i + 1)
			key(4, $unsigned($random(seed)) % 10);
		end_of_test;
	end
endmodule // front_panel_status_indicator_tb
